// ---- core/eis_pkg.sv ----
package eis_pkg;

  // Register bus address width and data width
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG = 8'h54;
  localparam logic [7:0] OFS_STATUS = 8'h58;
  localparam logic [7:0] OFS_ENABLE = 8'h5c;
  localparam logic [7:0] OFS_BYTE_TEST = 8'h64;
  localparam logic [7:0] OFS_FIFO_LEVEL = 8'h68;
  localparam logic [7:0] OFS_PIN_CFG = 8'hc0;
  localparam logic [7:0] OFS_POWER = 8'hc4;

  // Status flag bit positions
  localparam int BIT_SOFTWARE = 31;
  localparam int BIT_TX_HALTED = 25;
  localparam int BIT_RX_HALTED = 24;
  localparam int BIT_DROP_HALFWAY = 23;
  localparam int BIT_TX_NOTIFY = 21;
  localparam int BIT_RX_DMA = 20;
  localparam int BIT_TIMER_WRAP = 19;
  localparam int BIT_TRANSCEIVER = 18;
  localparam int BIT_POWER = 17;
  localparam int BIT_TSF_OVERFLOW = 16;
  localparam int BIT_RX_OVERSIZE = 15;
  localparam int BIT_RX_FAULT = 14;
  localparam int BIT_TX_FAULT = 13;
  localparam int BIT_TDF_OVERRUN = 10;
  localparam int BIT_TDF_SPACE = 9;
  localparam int BIT_TSF_FULL = 8;
  localparam int BIT_TSF_LEVEL = 7;
  localparam int BIT_FRAME_DROPPED = 6;
  localparam int BIT_RSF_FULL = 4;
  localparam int BIT_RSF_LEVEL = 3;
  localparam int BIT_PIN_LSB = 0;

  // Defined, clearable and enable masks
  localparam logic [31:0] STATUS_DEFINED_MASK = 32'h83bf_e7df;
  localparam logic [31:0] STATUS_CLEAR_MASK = 32'h83bb_e7df;
  localparam logic [31:0] ENABLE_MASK = 32'h83bf_e7df;

  // Configuration, FIFO level and power register fields
  localparam int CFG_HOLDOFF_LSB = 24;
  localparam int CFG_MASTER_BIT = 12;
  localparam int FIFO_TDF_LSB = 24;
  localparam int FIFO_TSF_LSB = 16;
  localparam int FIFO_RSF_LSB = 0;
  localparam int POWER_SLEEP_BIT = 0;

  // Reset values and constants
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [7:0] HOLDOFF_RESET = 8'h00;
  localparam logic [31:0] FIFO_LEVEL_RESET = 32'h4800_0000;
  localparam logic [2:0] PIN_CFG_RESET = 3'h0;
  localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;

  // Event thresholds
  localparam logic [31:0] DROP_BEFORE_MID = 32'h7fff_ffff;
  localparam logic [31:0] DROP_AFTER_MID = 32'h8000_0000;
  localparam logic [15:0] TIMER_WRAP_FROM = 16'h0000;
  localparam logic [15:0] TIMER_WRAP_TO = 16'hffff;
  localparam int FRAME_CNT_W = 12;
  localparam logic [11:0] FRAME_LIMIT_BYTES = 12'h800;

endpackage

// ---- core/eis_status.sv ----
// How it works
// - Writing one to a clearable flag clears it; writing zero keeps it.
// - Software flag bit 31 sets when its enable bit goes high.
// - Bit 25 sets once stop is requested and transmitter has halted.
// - Bit 24 sets when the receiver reaches its halted state.
// - Bit 23 sets when drop counter steps from 7fffffff to 80000000.
// - Bit 21 sets when a notify-marked transmit buffer is fully loaded.
// - Bit 20 sets once the programmed receive DMA length has been drained.
// - Bit 19 sets each time the down-counting timer wraps zero to ffff.
// - Bit 18 is read-only, follows transceiver event, ignores writes.
// - Bit 17 sets on power event whatever the wake signal; one clears.
// - Power events never wake; only a byte test write ends sleep.
// - Hold-off interval never delays the power event interrupt.
// - Bit 16 sets when a push meets a full transmit status FIFO.
// - Bit 15 sets when a received packet passes 2048 bytes.
// - Bit 14 sets on receiver error, bit 13 on transmitter error.
// - Bit 10 sets when the host writes a full transmit data FIFO.
// - Bit 9 sets when transmit data free space exceeds its threshold.
// - Bit 8 sets when the transmit status FIFO becomes full.
// - Bits 7 and 3 set when status FIFO occupancy exceeds threshold.
// - Bit 6 sets every time an incoming frame is dropped.
// - Bit 4 sets when the receive status FIFO becomes full.
// - Bits 2 to 0 latch pin events, edge chosen per pin.
// - Flags record events whether or not their enable is set.
// - Master indication is high while any enabled flag is set.
// - Transmit space threshold in 64-byte blocks, default 48h, strict compare.
// - Status FIFO thresholds in words, default 00h, event when exceeded.
`timescale 1ns/100ps
`default_nettype none

module eis_status #(
  parameter int PIN_COUNT = 3,
  parameter int RX_DMA_LEN_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_tx_stop_request,
  input wire logic i_tx_halted,
  input wire logic i_rx_halted,
  input wire logic [31:0] i_drop_count,
  input wire logic i_tx_buf_loaded,
  input wire logic i_tx_buf_notify,
  input wire logic i_rx_dma_load,
  input wire logic [RX_DMA_LEN_W-1:0] i_receive_dma_length,
  input wire logic i_rx_fifo_pop,
  input wire logic [15:0] i_timer_count,
  input wire logic i_transceiver_event,
  input wire logic i_power_event,
  input wire logic i_wake_enable,
  input wire logic i_tsf_push,
  input wire logic i_tsf_full,
  input wire logic [7:0] i_tsf_used,
  input wire logic i_rx_start,
  input wire logic i_rx_byte,
  input wire logic i_rx_error,
  input wire logic i_tx_error,
  input wire logic i_tdf_write,
  input wire logic [7:0] i_tdf_free,
  input wire logic i_frame_dropped,
  input wire logic i_rsf_full,
  input wire logic [7:0] i_rsf_used,
  input wire logic [PIN_COUNT-1:0] i_pins,
  output logic o_master_irq,
  output logic o_power_irq,
  output logic [7:0] o_holdoff_interval,
  output logic o_asleep
);

  // Elaboration checks on parameters
  if (PIN_COUNT < 1 || PIN_COUNT > 3) begin : g_bad_pins
    $error("PIN_COUNT must lie between 1 and 3");
  end
  if (RX_DMA_LEN_W < 1 || RX_DMA_LEN_W > 31) begin : g_bad_dma
    $error("RX_DMA_LEN_W must lie between 1 and 31");
  end

  // Register state
  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] enable_reg;
  logic [7:0] holdoff_reg;
  logic [7:0] tdf_level_reg;
  logic [7:0] tsf_level_reg;
  logic [7:0] rsf_level_reg;
  logic [2:0] pin_cfg_reg;
  logic asleep_reg;
  logic master_reg;
  logic power_irq_reg;
  logic [31:0] rdata_reg;

  // Event detection state
  logic [31:0] set_vec;
  logic [31:0] drop_prev_reg;
  logic [15:0] timer_prev_reg;
  logic tx_stop_prev_reg;
  logic rx_halt_prev_reg;
  logic tsf_full_prev_reg;
  logic rsf_full_prev_reg;
  logic tsf_level_prev_reg;
  logic rsf_level_prev_reg;
  logic tdf_space_prev_reg;
  logic [RX_DMA_LEN_W-1:0] dma_left_reg;
  logic [eis_pkg::FRAME_CNT_W-1:0] frame_bytes_reg;
  logic [PIN_COUNT-1:0] pin_meta_reg;
  logic [PIN_COUNT-1:0] pin_sync_reg;
  logic [PIN_COUNT-1:0] pin_prev_reg;

  // Decoded bus strobes
  logic wr_config;
  logic wr_status;
  logic wr_enable;
  logic wr_byte_test;
  logic wr_fifo_level;
  logic wr_pin_cfg;
  logic wr_power;
  logic sw_enable_rise;

  // Condition levels
  logic tx_stop_now;
  logic tsf_level_now;
  logic rsf_level_now;
  logic tdf_space_now;
  logic [PIN_COUNT-1:0] pin_event;
  logic [2:0] pin_event_full;

  // Address decode of write strobe
  assign wr_config = i_wr && (i_addr == eis_pkg::OFS_CONFIG);
  assign wr_status = i_wr && (i_addr == eis_pkg::OFS_STATUS);
  assign wr_enable = i_wr && (i_addr == eis_pkg::OFS_ENABLE);
  assign wr_byte_test = i_wr && (i_addr == eis_pkg::OFS_BYTE_TEST);
  assign wr_fifo_level = i_wr && (i_addr == eis_pkg::OFS_FIFO_LEVEL);
  assign wr_pin_cfg = i_wr && (i_addr == eis_pkg::OFS_PIN_CFG);
  assign wr_power = i_wr && (i_addr == eis_pkg::OFS_POWER);

  // Software enable going from low to high
  assign sw_enable_rise = wr_enable && i_wdata[eis_pkg::BIT_SOFTWARE]
                          && !enable_reg[eis_pkg::BIT_SOFTWARE];

  // Level conditions compared against thresholds
  assign tx_stop_now = i_tx_stop_request && i_tx_halted;
  assign tdf_space_now = i_tdf_free > tdf_level_reg;
  assign tsf_level_now = i_tsf_used > tsf_level_reg;
  assign rsf_level_now = i_rsf_used > rsf_level_reg;

  // Pin synchroniser, two flops before any logic
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= i_pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Pin edge select: one picks rising, zero picks falling
  always_comb begin
    pin_event_full = 3'h0;
    for (int p = 0; p < PIN_COUNT; p++) begin
      if (pin_cfg_reg[p]) begin
        pin_event_full[p] = pin_sync_reg[p] && !pin_prev_reg[p];
      end else begin
        pin_event_full[p] = !pin_sync_reg[p] && pin_prev_reg[p];
      end
    end
  end
  assign pin_event = pin_event_full[PIN_COUNT-1:0];

  // Previous values for edge and wrap detection
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drop_prev_reg <= '0;
      timer_prev_reg <= '0;
      tx_stop_prev_reg <= 1'b0;
      rx_halt_prev_reg <= 1'b0;
      tsf_full_prev_reg <= 1'b0;
      rsf_full_prev_reg <= 1'b0;
      tsf_level_prev_reg <= 1'b0;
      rsf_level_prev_reg <= 1'b0;
      tdf_space_prev_reg <= 1'b0;
    end else begin
      drop_prev_reg <= i_drop_count;
      timer_prev_reg <= i_timer_count;
      tx_stop_prev_reg <= tx_stop_now;
      rx_halt_prev_reg <= i_rx_halted;
      tsf_full_prev_reg <= i_tsf_full;
      rsf_full_prev_reg <= i_rsf_full;
      tsf_level_prev_reg <= tsf_level_now;
      rsf_level_prev_reg <= rsf_level_now;
      tdf_space_prev_reg <= tdf_space_now;
    end
  end

  // Receive DMA remaining length
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dma_left_reg <= '0;
    end else if (i_rx_dma_load) begin
      dma_left_reg <= i_receive_dma_length;
    end else if (i_rx_fifo_pop && (dma_left_reg != '0)) begin
      dma_left_reg <= dma_left_reg - RX_DMA_LEN_W'(1);
    end
  end

  // Received packet length, saturating past the limit
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frame_bytes_reg <= '0;
    end else if (i_rx_start) begin
      frame_bytes_reg <= i_rx_byte ? eis_pkg::FRAME_CNT_W'(1) : '0;
    end else if (i_rx_byte && (frame_bytes_reg <= eis_pkg::FRAME_LIMIT_BYTES)) begin
      frame_bytes_reg <= frame_bytes_reg + eis_pkg::FRAME_CNT_W'(1);
    end
  end

  // Event sources, each a one-cycle set request
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[eis_pkg::BIT_SOFTWARE] = sw_enable_rise;
    set_vec[eis_pkg::BIT_TX_HALTED] = tx_stop_now && !tx_stop_prev_reg;
    set_vec[eis_pkg::BIT_RX_HALTED] = i_rx_halted && !rx_halt_prev_reg;
    set_vec[eis_pkg::BIT_DROP_HALFWAY] =
      (drop_prev_reg == eis_pkg::DROP_BEFORE_MID)
      && (i_drop_count == eis_pkg::DROP_AFTER_MID);
    set_vec[eis_pkg::BIT_TX_NOTIFY] = i_tx_buf_loaded && i_tx_buf_notify;
    set_vec[eis_pkg::BIT_RX_DMA] = !i_rx_dma_load && i_rx_fifo_pop
      && (dma_left_reg == RX_DMA_LEN_W'(1));
    set_vec[eis_pkg::BIT_TIMER_WRAP] =
      (timer_prev_reg == eis_pkg::TIMER_WRAP_FROM)
      && (i_timer_count == eis_pkg::TIMER_WRAP_TO);
    // Power event ignores the wake signal enable
    set_vec[eis_pkg::BIT_POWER] = i_power_event;
    set_vec[eis_pkg::BIT_TSF_OVERFLOW] = i_tsf_push && i_tsf_full;
    set_vec[eis_pkg::BIT_RX_OVERSIZE] = i_rx_byte && !i_rx_start
      && (frame_bytes_reg == eis_pkg::FRAME_LIMIT_BYTES);
    set_vec[eis_pkg::BIT_RX_FAULT] = i_rx_error;
    set_vec[eis_pkg::BIT_TX_FAULT] = i_tx_error;
    set_vec[eis_pkg::BIT_TDF_OVERRUN] = i_tdf_write && (i_tdf_free == 8'h00);
    set_vec[eis_pkg::BIT_TDF_SPACE] = tdf_space_now && !tdf_space_prev_reg;
    set_vec[eis_pkg::BIT_TSF_FULL] = i_tsf_full && !tsf_full_prev_reg;
    set_vec[eis_pkg::BIT_TSF_LEVEL] = tsf_level_now && !tsf_level_prev_reg;
    set_vec[eis_pkg::BIT_FRAME_DROPPED] = i_frame_dropped;
    set_vec[eis_pkg::BIT_RSF_FULL] = i_rsf_full && !rsf_full_prev_reg;
    set_vec[eis_pkg::BIT_RSF_LEVEL] = rsf_level_now && !rsf_level_prev_reg;
    set_vec[eis_pkg::BIT_PIN_LSB +: PIN_COUNT] = pin_event;
  end

  // Flag update: clear by writing one, set beats clear
  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_next & ~(i_wdata & eis_pkg::STATUS_CLEAR_MASK);
    end
    status_next = status_next | set_vec;
    status_next[eis_pkg::BIT_TRANSCEIVER] = i_transceiver_event;
    status_next = status_next & eis_pkg::STATUS_DEFINED_MASK;
  end

  // Status flags
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_reg <= eis_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Enable mask register
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable_reg <= eis_pkg::ENABLE_RESET;
    end else if (wr_enable) begin
      enable_reg <= i_wdata & eis_pkg::ENABLE_MASK;
    end
  end

  // Hold-off interval field, used by the pin timer outside
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      holdoff_reg <= eis_pkg::HOLDOFF_RESET;
    end else if (wr_config) begin
      holdoff_reg <= i_wdata[eis_pkg::CFG_HOLDOFF_LSB +: 8];
    end
  end

  // FIFO threshold levels
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tdf_level_reg <= eis_pkg::FIFO_LEVEL_RESET[eis_pkg::FIFO_TDF_LSB +: 8];
      tsf_level_reg <= eis_pkg::FIFO_LEVEL_RESET[eis_pkg::FIFO_TSF_LSB +: 8];
      rsf_level_reg <= eis_pkg::FIFO_LEVEL_RESET[eis_pkg::FIFO_RSF_LSB +: 8];
    end else if (wr_fifo_level) begin
      tdf_level_reg <= i_wdata[eis_pkg::FIFO_TDF_LSB +: 8];
      tsf_level_reg <= i_wdata[eis_pkg::FIFO_TSF_LSB +: 8];
      rsf_level_reg <= i_wdata[eis_pkg::FIFO_RSF_LSB +: 8];
    end
  end

  // Pin edge selection register
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_cfg_reg <= eis_pkg::PIN_CFG_RESET;
    end else if (wr_pin_cfg) begin
      pin_cfg_reg <= i_wdata[2:0];
    end
  end

  // Sleep state: entered by software, left only by byte test write
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      asleep_reg <= 1'b0;
    end else if (wr_byte_test) begin
      asleep_reg <= 1'b0;
    end else if (wr_power && i_wdata[eis_pkg::POWER_SLEEP_BIT]) begin
      asleep_reg <= 1'b1;
    end
  end

  // Interrupt indications, neither one held off
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      master_reg <= 1'b0;
      power_irq_reg <= 1'b0;
    end else begin
      master_reg <= |(status_reg & enable_reg);
      power_irq_reg <= status_reg[eis_pkg::BIT_POWER]
                       && enable_reg[eis_pkg::BIT_POWER];
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 32'h0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        eis_pkg::OFS_CONFIG: begin
          rdata_reg <= {holdoff_reg, 11'h000, master_reg, 12'h000};
        end
        eis_pkg::OFS_STATUS: begin
          rdata_reg <= status_reg;
        end
        eis_pkg::OFS_ENABLE: begin
          rdata_reg <= enable_reg;
        end
        eis_pkg::OFS_BYTE_TEST: begin
          rdata_reg <= eis_pkg::BYTE_TEST_VALUE;
        end
        eis_pkg::OFS_FIFO_LEVEL: begin
          rdata_reg <= {tdf_level_reg, tsf_level_reg, 8'h00, rsf_level_reg};
        end
        eis_pkg::OFS_PIN_CFG: begin
          rdata_reg <= {29'h0000_0000, pin_cfg_reg};
        end
        eis_pkg::OFS_POWER: begin
          rdata_reg <= {31'h0000_0000, asleep_reg};
        end
        default: begin
          rdata_reg <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Outputs from flops
  assign o_rdata = rdata_reg;
  assign o_master_irq = master_reg;
  assign o_power_irq = power_irq_reg;
  assign o_holdoff_interval = holdoff_reg;
  assign o_asleep = asleep_reg;

  // Wake enable only matters to the pin driver outside
  logic unused_wake;
  assign unused_wake = i_wake_enable;

endmodule

`default_nettype wire

// ---- tb/eis_status_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

module eis_status_monitor (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_power_event,
  input wire logic [31:0] o_rdata,
  input wire logic o_master_irq,
  input wire logic o_power_irq,
  input wire logic o_asleep
);
  logic [31:0] en_reg;
  logic en_any;
  logic wr_test;

  // Shadow of the enable register, built from host writes
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_reg <= 32'h0;
    end else if (i_wr && i_addr == eis_pkg::OFS_ENABLE) begin
      en_reg <= i_wdata & eis_pkg::ENABLE_MASK;
    end
  end

  // Any source enabled; host write to the byte test word
  assign en_any = |en_reg;
  assign wr_test = i_wr && (i_addr == eis_pkg::OFS_BYTE_TEST);

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  a_reserved_zero: assert property ($past(i_rd) && $past(i_addr) == eis_pkg::OFS_STATUS
    |-> (o_rdata & ~eis_pkg::STATUS_DEFINED_MASK) == 32'h0)
    else $error("reserved status bits read nonzero");
  a_enable_readback: assert property ($past(i_rd) && $past(i_addr) == eis_pkg::OFS_ENABLE
    |-> o_rdata == $past(en_reg))
    else $error("enable readback differs from written value");
  a_power_deliver: assert property (i_power_event ##1 en_reg[eis_pkg::BIT_POWER]
    |-> ##1 o_power_irq)
    else $error("power event not delivered in two cycles");
  a_power_cause: assert property (o_power_irq |-> $past(en_reg[17]))
    else $error("power indication without its enable");
  a_power_master: assert property (o_power_irq |-> o_master_irq)
    else $error("power indication without master indication");
  a_master_cause: assert property (o_master_irq |-> $past(en_any))
    else $error("master indication with no source enabled");
  a_sleep_hold: assert property (o_asleep && !wr_test |=> o_asleep)
    else $error("left sleep without a byte test write");
  a_wake_write: assert property (o_asleep && wr_test |=> !o_asleep)
    else $error("byte test write did not wake");

  c_power: cover property (i_power_event);
  c_wake: cover property (o_asleep && wr_test);
  c_master: cover property ($rose(o_master_irq));
endmodule

bind eis_status eis_status_monitor u_eis_status_monitor (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_power_event(i_power_event), .o_rdata(o_rdata),
  .o_master_irq(o_master_irq), .o_power_irq(o_power_irq), .o_asleep(o_asleep));

`default_nettype wire

// ---- tb/eis_host.sv ----
`timescale 1ns/100ps
`default_nettype none

module eis_host (
  input wire logic i_mclk,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [31:0] i_rdata
);
  // Idle bus at time zero
  initial begin
    o_addr = 8'h0;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write; flags are acknowledged by writing ones, wake by byte test
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    #1;
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

`default_nettype wire

// ---- tb/tb_eis_status.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_eis_status;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, got, d;
  logic i_wr, i_rd, master, pwr, asleep;
  logic [7:0] holdoff;
  logic [5:0] ev = 6'h0;
  logic stop_req = 1'b0, tx_halt = 1'b0, rx_halt = 1'b0, wake_en = 1'b0, phy = 1'b0;
  logic dma_load = 1'b0, pop = 1'b0, push = 1'b0, tsf_full = 1'b0, rsf_full = 1'b0;
  logic rx_start = 1'b0, rx_byte = 1'b0, notify = 1'b1;
  logic [31:0] drop = 32'h0, exp_sts = 32'h0, exp_en = 32'h0;
  logic [15:0] timer = 16'h0001;
  logic [7:0] tsf_used = 8'h0, rsf_used = 8'h0, tdf_free = 8'h0;
  logic [2:0] pins = 3'h7;
  int n_fail = 0, tests_run = 0, seed = 93461;
  int bits [6] = '{13, 14, 6, 17, 21, 10};
  logic [7:0] ra [8] = '{8'h54, 8'h58, 8'h5c, 8'h68, 8'h64, 8'h60, 8'hc0, 8'hc4};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h4800_0000, 32'h8765_4321, 32'h0, 32'h0, 32'h0};

  // Clock, 100 ns period
  always #50 i_mclk = ~i_mclk;

  eis_status u_eis_status (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tx_stop_request(stop_req), .i_tx_halted(tx_halt), .i_rx_halted(rx_halt),
    .i_drop_count(drop), .i_tx_buf_loaded(ev[4]), .i_tx_buf_notify(notify),
    .i_rx_dma_load(dma_load), .i_receive_dma_length(12'h2), .i_rx_fifo_pop(pop),
    .i_timer_count(timer), .i_transceiver_event(phy), .i_power_event(ev[3]),
    .i_wake_enable(wake_en), .i_tsf_push(push), .i_tsf_full(tsf_full), .i_tsf_used(tsf_used),
    .i_rx_start(rx_start), .i_rx_byte(rx_byte), .i_rx_error(ev[1]), .i_tx_error(ev[0]),
    .i_tdf_write(ev[5]), .i_tdf_free(tdf_free), .i_frame_dropped(ev[2]), .i_rsf_full(rsf_full),
    .i_rsf_used(rsf_used), .i_pins(pins), .o_master_irq(master), .o_power_irq(pwr),
    .o_holdoff_interval(holdoff), .o_asleep(asleep));

  eis_host u_eis_host (.i_mclk(i_mclk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd), .i_rdata(o_rdata));

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  // Status read against the model
  task automatic sts(input string what);
    u_eis_host.read(eis_pkg::OFS_STATUS, got);
    check(what, exp_sts, got);
  endtask

  // Write-one-to-clear, mirrored in the model
  task automatic clr(input logic [31:0] m);
    u_eis_host.write(eis_pkg::OFS_STATUS, m);
    exp_sts = exp_sts & ~(m & eis_pkg::STATUS_CLEAR_MASK);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic pulse(input logic [5:0] v);
    ev <= v;
    @(posedge i_mclk);
    ev <= 6'h0;
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #1_000_000;
    n_fail++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    cyc(5);
    i_rst_b <= 1'b1;
    u_eis_host.write(8'h60, 32'hffff_ffff);
    for (int k = 0; k < 8; k++) begin
      u_eis_host.read(ra[k], got);
      check("reset read", rv[k], got);
    end
    // Pulse sources with nothing enabled
    for (int k = 0; k < 6; k++) begin
      wake_en <= 1'($random(seed));
      pulse(6'h1 << k);
      exp_sts[bits[k]] = 1'b1;
      sts("event flag");
      clr(32'h0);
      sts("write zero");
      clr(32'h1 << bits[k]);
      sts("write one");
    end
    // Buffer loaded without its notify marker sets nothing
    notify <= 1'b0;
    pulse(6'h10);
    notify <= 1'b1;
    sts("loaded no notify");
    check("master off", 32'h0, {31'h0, master});
    ev <= 6'h1;
    clr(32'h2000);
    ev <= 6'h0;
    exp_sts[13] = 1'b1;
    sts("set wins");
    // Random enables, software flag on rising enable
    for (int k = 0; k < 5; k++) begin
      d = (k == 4) ? 32'hffff_ffff : $random(seed);
      u_eis_host.write(eis_pkg::OFS_ENABLE, d);
      if (d[31] && !exp_en[31]) exp_sts[31] = 1'b1;
      exp_en = d & eis_pkg::ENABLE_MASK;
      u_eis_host.read(eis_pkg::OFS_ENABLE, got);
      check("enable", exp_en, got);
      sts("software flag");
      check("master", {31'h0, |(exp_sts & exp_en)}, {31'h0, master});
    end
    d = $random(seed);
    u_eis_host.write(eis_pkg::OFS_CONFIG, d);
    check("holdoff", {24'h0, d[31:24]}, {24'h0, holdoff});
    // Sleep, power event, wake by byte test write
    u_eis_host.write(eis_pkg::OFS_POWER, 32'h1);
    pulse(6'h8);
    exp_sts[17] = 1'b1;
    cyc(1);
    check("power irq", 32'h1, {31'h0, pwr});
    check("asleep", 32'h1, {31'h0, asleep});
    u_eis_host.write(eis_pkg::OFS_BYTE_TEST, d);
    check("awake", 32'h0, {31'h0, asleep});
    clr(32'h2_2000);
    sts("power clear");
    // Level sources, thresholds at their boundary
    u_eis_host.write(eis_pkg::OFS_FIFO_LEVEL, 32'h4802_0002);
    {tx_halt, rx_halt, phy, tsf_full, rsf_full} <= 5'h1f;
    {drop, timer, tsf_used, rsf_used, tdf_free} <= {32'h7fff_ffff, 16'h0, 8'h2, 8'h2, 8'h48};
    cyc(1);
    exp_sts = exp_sts | 32'h0104_0110;
    sts("levels before");
    {stop_req, push} <= 2'h3;
    {drop, timer, tsf_used, rsf_used, tdf_free} <= {32'h8000_0000, 16'hffff, 8'h3, 8'h3, 8'h49};
    cyc(1);
    push <= 1'b0;
    exp_sts = exp_sts | 32'h0289_0288;
    sts("levels after");
    clr(32'hffff_ffff);
    sts("clear all");
    // Pin events, falling then rising
    pins <= 3'h0;
    cyc(4);
    exp_sts[2:0] = 3'h7;
    sts("pins falling");
    u_eis_host.write(eis_pkg::OFS_PIN_CFG, 32'h7);
    clr(32'h7);
    pins <= 3'h7;
    cyc(4);
    exp_sts[2:0] = 3'h7;
    sts("pins rising");
    // Receive DMA length drained
    dma_load <= 1'b1;
    cyc(1);
    dma_load <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      pop <= 1'b1;
      cyc(1);
      pop <= 1'b0;
      exp_sts[20] = (k == 1);
      sts("dma");
    end
    // Packet of 2048 bytes, then one more
    {rx_start, rx_byte} <= 2'h3;
    cyc(1);
    rx_start <= 1'b0;
    cyc(2047);
    rx_byte <= 1'b0;
    sts("size limit");
    rx_byte <= 1'b1;
    cyc(1);
    rx_byte <= 1'b0;
    exp_sts[15] = 1'b1;
    sts("oversize");
    report_and_stop;
  end
endmodule

`default_nettype wire
